/* File: alc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module alc_regs (
  input  wire logic                core_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                sclk_i,
  input  wire logic                cs_b_i,
  input  wire logic                sdi_i,
  output logic                     sdo_o,
  output logic                     sdo_oe_o,
  output logic [15:0]              channel_low_limit_o,
  output logic                     frame_done_o
);
  import alc_pkg::*;

  alc_pins_t  pins_s;
  logic       sclk_q;
  logic       rise_s;
  logic       fall_s;
  logic       active_s;
  logic [5:0] edge_cnt_q;
  logic [15:0] cmd_shift_q;
  logic [15:0] out_shift_q;
  logic [7:0] low_upper_q;
  logic [7:0] low_lower_q;
  logic [7:0] echo_q;
  logic [7:0] rd_byte_s;
  logic [6:0] addr_s;
  logic       wr_s;
  logic       load_s;
  logic       cmd_valid_q;

  function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [7:0] up,
                                          input logic [7:0] lo, input logic [7:0] ec);
    unique case (addr)
      ALC_LOW_UPPER_ADDR: reg_read = up;
      ALC_LOW_LOWER_ADDR: reg_read = lo;
      ALC_ECHO_ADDR:      reg_read = ec;
      default:            reg_read = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin sampling; serial clock is just another slow input
  // ----------------------------------------------------------------
  // Reset to idle levels, else a select low would be seen for two clocks after reset
  alc_sync #(.WIDTH(3), .RST_VAL(ALC_PINS_IDLE)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    ({sclk_i, cs_b_i, sdi_i}),
    .sync_o     (pins_s)
  );

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= pins_s.sclk;
    end
  end

  assign active_s = !pins_s.cs_b;
  assign rise_s   = active_s && pins_s.sclk && !sclk_q;
  assign fall_s   = active_s && !pins_s.sclk && sclk_q;
  assign addr_s   = cmd_shift_q[ALC_ADDR_MSB:ALC_ADDR_LSB];
  assign wr_s     = cmd_shift_q[ALC_WR_BIT];
  // Sixteenth falling edge: the whole command word is already in the shifter
  assign load_s   = fall_s && edge_cnt_q == ALC_ECHO_START - 6'd1;
  assign rd_byte_s = reg_read(addr_s, low_upper_q, low_lower_q, echo_q);

  // ----------------------------------------------------------------
  // Frame edge counter, counts falling edges
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      edge_cnt_q <= '0;
    end else if (!active_s) begin
      edge_cnt_q <= '0;
    end else if (fall_s && edge_cnt_q != ALC_FRAME_MAX) begin
      edge_cnt_q <= edge_cnt_q + 6'd1;
    end
  end

  // Input shifts on rising edge during command phase
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_shift_q <= '0;
    end else if (rise_s && edge_cnt_q < ALC_ECHO_START) begin
      cmd_shift_q <= {cmd_shift_q[14:0], pins_s.sdi};
    end
  end

  // Command is complete once 16 bits are in; the flag clears when the frame ends
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_valid_q <= 1'b0;
    end else if (!active_s) begin
      cmd_valid_q <= 1'b0;
    end else if (load_s) begin
      cmd_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Threshold byte registers: any value kept as written
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_upper_q <= ALC_LOW_RESET;
      low_lower_q <= ALC_LOW_RESET;
    end else if (load_s && wr_s) begin
      // Data comes from the shifter; the live pin already carries the next bit
      if (addr_s == ALC_LOW_UPPER_ADDR) begin
        low_upper_q <= cmd_shift_q[7:0];
      end
      if (addr_s == ALC_LOW_LOWER_ADDR) begin
        low_lower_q <= cmd_shift_q[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command echo: captured at frame end, read-only to the host
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      echo_q <= ALC_ECHO_RESET;
    end else if (cmd_valid_q && !active_s) begin
      // Echo updates only between frames so a read sees the prior frame
      echo_q <= cmd_shift_q[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Output shifter: loaded at 16th falling edge, MSB first
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_shift_q <= '0;
      sdo_o       <= 1'b0;
    end else if (!active_s) begin
      out_shift_q <= '0;
      sdo_o       <= 1'b0;
    end else if (load_s) begin
      // Read data plus eight zero bits
      out_shift_q <= {rd_byte_s, 8'h00};
      sdo_o       <= rd_byte_s[7];
    end else if (fall_s && edge_cnt_q >= ALC_ECHO_START) begin
      out_shift_q <= {out_shift_q[14:0], 1'b0};
      sdo_o       <= out_shift_q[14];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_oe_o <= active_s;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      channel_low_limit_o <= {ALC_LOW_RESET, ALC_LOW_RESET};
      frame_done_o        <= 1'b0;
    end else begin
      channel_low_limit_o <= {low_upper_q, low_lower_q};
      frame_done_o        <= cmd_valid_q && !active_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_limit_concat;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      ##1 channel_low_limit_o == {$past(low_upper_q), $past(low_lower_q)};
  endproperty
  a_limit_concat: assert property (p_limit_concat) else $error("limit mismatch");

  property p_hold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !fall_s |=> $stable(low_upper_q) && $stable(low_lower_q);
  endproperty
  a_hold: assert property (p_hold) else $error("threshold changed unexpectedly");

  property p_write_upper;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (load_s && wr_s && addr_s == ALC_LOW_UPPER_ADDR) |=> low_upper_q == $past(cmd_shift_q[7:0]);
  endproperty
  a_write_upper: assert property (p_write_upper) else $error("upper byte not written");

  property p_echo_ro;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      active_s |=> $stable(echo_q);
  endproperty
  a_echo_ro: assert property (p_echo_ro) else $error("echo changed in frame");

  property p_echo_capture;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (cmd_valid_q && !active_s) |=> echo_q == $past(cmd_shift_q[15:8]);
  endproperty
  a_echo_capture: assert property (p_echo_capture) else $error("echo not captured");

  property p_tail_zero;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (active_s && edge_cnt_q > ALC_ECHO_START + 6'd8) |-> !sdo_o;
  endproperty
  a_tail_zero: assert property (p_tail_zero) else $error("tail bits not zero");

  property p_quiet_before;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (edge_cnt_q < ALC_ECHO_START) |=> (edge_cnt_q < ALC_ECHO_START) || !sdo_o
        || $past(fall_s);
  endproperty
  a_quiet_before: assert property (p_quiet_before) else $error("early sdo");

  property p_reset_zero;
    @(posedge core_clk_i) $rose(rst_b_i) |-> low_upper_q == 8'h00 && low_lower_q == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

  property p_oe;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !pins_s.cs_b |=> sdo_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("sdo not enabled");
endmodule
`default_nettype wire

/* File: alc_pkg.sv */
// Overview of operation
// - Upper threshold byte register, addr 18h, reset zero
// - Lower threshold byte register, addr 19h, reset zero
// - Threshold is upper byte then lower byte
// - Any byte value accepted and used unchanged
// - Read-only command echo register at 3Fh
// - Echo returns previous frame's command upper byte
// - Echo on SDO from 16th falling edge, MSB first
// - Eight command bits, then eight zero bits
// - Echo holds previous command upper byte, resets zero
`default_nettype none
package alc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ALC_LOW_UPPER_ADDR = 7'h18;
  localparam logic [6:0] ALC_LOW_LOWER_ADDR = 7'h19;
  localparam logic [6:0] ALC_ECHO_ADDR      = 7'h3f;
  localparam logic [7:0] ALC_LOW_RESET      = 8'h00;
  localparam logic [7:0] ALC_ECHO_RESET     = 8'h00;
  // ----------------------------------------------------------------
  // Frame layout: 16 command bits in, then data out
  // ----------------------------------------------------------------
  localparam int         ALC_CMD_BITS       = 16;
  localparam logic [5:0] ALC_ECHO_START     = 6'd16;
  localparam logic [5:0] ALC_FRAME_MAX      = 6'd32;
  localparam logic [7:0] ALC_OP_NOP         = 8'h00;
  localparam int         ALC_ADDR_MSB       = 15;
  localparam int         ALC_ADDR_LSB       = 9;
  localparam int         ALC_WR_BIT         = 8;

  typedef struct packed {
    logic sclk;
    logic cs_b;
    logic sdi;
  } alc_pins_t;

  // Idle pin levels; the synchroniser resets to these so no false select follows reset
  localparam alc_pins_t  ALC_PINS_IDLE      = '{sclk: 1'b0, cs_b: 1'b1, sdi: 1'b0};
endpackage
`default_nettype wire

/* File: alc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module alc_sync #(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------
  // Two-stage synchroniser; first stage is read by nothing else
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: alc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module alc_host_model (
  input  wire logic               core_clk_i,
  input  wire logic               sdo_i,
  output var  alc_pkg::alc_pins_t pins_o
);
  import alc_pkg::*;
  logic [15:0] rd_word;
  event        done_ev;
  initial begin
    pins_o = '{sclk: 1'b0, cs_b: 1'b1, sdi: 1'b0};
  end
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // Half a serial period is 4 core clocks, so every move lands on a core falling edge
  task automatic half();
    repeat (4) @(negedge core_clk_i);
  endtask
  task automatic xfer(input logic [15:0] cmd, input int nclk, input bit note);
    logic [15:0] cap;
    cap = 16'h0000;
    pins_o.cs_b = 1'b0;
    half();
    for (int i = 0; i < nclk; i++) begin
      // Past the command the data line toggles, so stale bits cannot pass
      pins_o.sdi = (i < 16) ? cmd[15-i] : ~pins_o.sdi;
      half();
      pins_o.sclk = 1'b1;
      half();
      if (i >= 16) cap = {cap[14:0], sdo_i};
      pins_o.sclk = 1'b0;
    end
    half();
    pins_o.cs_b = 1'b1;
    pins_o.sdi = ~pins_o.sdi;
    rd_word = cap << (32 - nclk);
    repeat (8) @(negedge core_clk_i);
    if (note) ->done_ev;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import alc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b;
  alc_pins_t   pins;
  logic        sdo;
  logic        sdo_oe;
  logic        frame_done;
  logic [15:0] limit;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [15:0] lim_q[$];
  logic [15:0] rd_q[$];
  logic [7:0]  up = 8'h00;
  logic [7:0]  lo = 8'h00;
  logic [7:0]  echo = 8'h00;
  logic [7:0]  v;

  alc_regs dut_u (.core_clk_i(core_clk), .rst_b_i(rst_b), .sclk_i(pins.sclk),
    .cs_b_i(pins.cs_b), .sdi_i(pins.sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .channel_low_limit_o(limit), .frame_done_o(frame_done));
  alc_host_model host_u (.core_clk_i(core_clk), .sdo_i(sdo), .pins_o(pins));

  always #12.5 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // Result watchers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  always @(negedge core_clk) if (frame_done === 1'b1) check(limit, lim_q.pop_front(), "limit");
  always @(host_u.done_ev) check(host_u.rd_word, rd_q.pop_front(), "readout");
  // Output enable must follow the select: high under every clock pulse, low once a frame ends
  always @(posedge pins.sclk) check({15'h0000, sdo_oe}, 16'h0001, "oe in frame");
  always @(negedge core_clk) if (frame_done === 1'b1) check({15'h0000, sdo_oe}, 16'h0000, "oe idle");
  // ----------------------------------------------------------------
  // Reference model and frames
  // ----------------------------------------------------------------
  task automatic frame(input logic [6:0] a, input logic wr, input logic [7:0] d, input int n);
    logic [15:0] e;
    case (a)
      ALC_LOW_UPPER_ADDR: e = {up, 8'h00};
      ALC_LOW_LOWER_ADDR: e = {lo, 8'h00};
      ALC_ECHO_ADDR:      e = {echo, 8'h00};
      default:            e = 16'h0000;
    endcase
    if (wr && a == ALC_LOW_UPPER_ADDR) up = d;
    if (wr && a == ALC_LOW_LOWER_ADDR) lo = d;
    lim_q.push_back({up, lo});
    if (!wr) rd_q.push_back(e);
    echo = {a, wr};
    host_u.xfer({a, wr, d}, n, !wr);
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    up = 8'h00;
    lo = 8'h00;
    echo = 8'h00;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Ceiling is about two and a half times the expected run of some forty frames
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 25000) begin
      fail_count++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h802a2c42));
    do_reset();
    frame(ALC_ECHO_ADDR, 1'b0, 8'h00, 32);
    frame(ALC_LOW_UPPER_ADDR, 1'b0, 8'h00, 32);
    frame(ALC_LOW_LOWER_ADDR, 1'b0, 8'h00, 32);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      frame(ALC_LOW_UPPER_ADDR, 1'b1, v, 32);
      frame(ALC_LOW_LOWER_ADDR, 1'b1, ~v, 32);
      frame(ALC_ECHO_ADDR, 1'b0, 8'h00, (i % 2) ? 24 : 32);
      frame(ALC_LOW_UPPER_ADDR, 1'b0, 8'h00, 32);
      frame(ALC_LOW_LOWER_ADDR, 1'b0, 8'h00, 32);
    end
    frame(ALC_ECHO_ADDR, 1'b1, 8'haa, 32);
    frame(ALC_ECHO_ADDR, 1'b0, 8'h00, 32);
    frame(7'h20, 1'b0, 8'h00, 32);
    do_reset();
    frame(ALC_LOW_UPPER_ADDR, 1'b0, 8'h00, 32);
    frame(ALC_ECHO_ADDR, 1'b0, 8'h00, 32);
    final_report();
  end
endmodule
`default_nettype wire
